// ---- rtl/mac_cfg.svh ----
// Purpose: constants for the collision window / retry limit and management command block
// Assumes: 32-bit classic Wishbone data path, word-aligned registers
// Notes:   word index is address bits 5:2
`ifndef MAC_CFG_SVH
`define MAC_CFG_SVH

// ==========================================
// register word indices
`define IDX_CLRT      4'h0
`define IDX_CLRT_SET  4'h1
`define IDX_CLRT_CLR  4'h2
`define IDX_CLRT_INV  4'h3
`define IDX_MCMD      4'h4
`define IDX_MCMD_SET  4'h5
`define IDX_MCMD_CLR  4'h6
`define IDX_MCMD_INV  4'h7
`define IDX_MRDD      4'h8
`define IDX_MWTD      4'h9
`define IDX_MADR      4'hA
`define IDX_MIND      4'hB

// ==========================================
// field positions and reset values
`define CW_MSB        13
`define CW_LSB        8
`define CW_RST        6'h37
`define RL_MSB        3
`define RL_LSB        0
`define RL_RST        4'hF
`define SCAN_BIT      1
`define READ_BIT      0
`define PHY_MSB       12
`define PHY_LSB       8
`define REGA_MSB      4
`define REGA_LSB      0
`define BUSY_BIT      0
`define WDAT_MSB      15

// ==========================================
// legal byte-select patterns (16-bit low, 16-bit high, 32-bit)
`define SEL_LO        4'h3
`define SEL_HI        4'hC
`define SEL_ALL       4'hF

// ==========================================
// management frame layout, bit numbers within the 64-bit frame
`define MII_PRE_BITS  6'h20
`define MII_TA_BIT    6'h2E
`define MII_DATA_BIT  6'h30
`define MII_LAST_BIT  6'h3F
`define MII_ST        2'h1
`define MII_OP_RD     2'h2
`define MII_OP_WR     2'h1
`define MII_TA_WR     2'h2

`endif

// ---- rtl/mac_pkg.sv ----
// Purpose: shared types for the collision / management command block
// Assumes: nothing beyond the cfg header
// Notes:   state codes are one-hot
package mac_pkg;
  typedef enum logic [1:0] {
    MG_IDLE = 2'h1,
    MG_RUN  = 2'h2
  } mgmt_state_t;

  typedef enum logic [2:0] {
    TX_IDLE   = 3'h1,
    TX_WINDOW = 3'h2,
    TX_LATE   = 3'h4
  } tx_state_t;

  typedef enum logic [1:0] {
    OP_WRITE = 2'h0,
    OP_SET   = 2'h1,
    OP_CLR   = 2'h2,
    OP_INV   = 2'h3
  } alias_op_t;
endpackage

// ---- rtl/mgmt_cycle_engine.sv ----
// Purpose: runs one management frame (read or write) on mdc / mdio
// Assumes: start only while busy is low; mdioIn synchronous to core_clk
// Notes:   mdio changes after mdc falls, read data sampled when mdc rises
`timescale 1ns/1ps
`default_nettype none
`include "mac_cfg.svh"

module mgmt_cycle_engine #(
  parameter int HALF_DIV = 20                 // core cycles per mdc half period
) (
  input  wire logic        core_clk,          // system clock
  input  wire logic        rstn,              // async reset, active low
  input  wire logic        ce,                // clock enable, freezes state
  input  wire logic        start,             // pulse: begin a frame
  input  wire logic        isRead,            // frame type for this start
  input  wire logic [4:0]  phyAddr,           // phy address
  input  wire logic [4:0]  regAddr,           // phy register address
  input  wire logic [15:0] wrData,            // data for a write frame
  output logic             busy,              // frame in progress
  output logic             done,              // pulse: frame finished
  output logic [15:0]      rdData,            // data of the last read frame
  output logic             mdc,               // management clock
  output logic             mdioOut,           // mdio drive value
  output logic             mdioOe,            // mdio drive enable
  input  wire logic        mdioIn             // mdio pin level
);
  import mac_pkg::*;

  mgmt_state_t stateReg, stateNext;
  logic [15:0] divReg, divNext;
  logic        mdcReg, mdcNext;
  logic [5:0]  bitReg, bitNext;
  logic [31:0] shReg, shNext;
  logic [15:0] rdReg, rdNext;
  logic        readOpReg, readOpNext;
  logic        doneReg, doneNext;
  logic        outReg, outNext;
  logic        oeReg, oeNext;
  logic        tick;

  // ==========================================
  // frame sequencer
  always_comb begin
    stateNext  = stateReg;
    divNext    = divReg;
    mdcNext    = mdcReg;
    bitNext    = bitReg;
    shNext     = shReg;
    rdNext     = rdReg;
    readOpNext = readOpReg;
    doneNext   = 1'b0;
    outNext    = outReg;
    oeNext     = oeReg;
    tick       = (divReg == 16'(HALF_DIV - 1));
    unique case (stateReg)
      MG_IDLE: begin
        mdcNext = 1'b0;
        oeNext  = 1'b0;
        if (start) begin
          stateNext  = MG_RUN;
          divNext    = '0;
          bitNext    = '0;
          readOpNext = isRead;
          shNext     = {`MII_ST, (isRead ? `MII_OP_RD : `MII_OP_WR), phyAddr, regAddr,
                        `MII_TA_WR, (isRead ? 16'h0000 : wrData)};
          outNext    = 1'b1;                  // preamble ones
          oeNext     = 1'b1;
        end
      end
      MG_RUN: begin
        divNext = tick ? '0 : divReg + 16'h0001;
        if (tick) begin
          mdcNext = ~mdcReg;
          if (!mdcReg) begin
            // rising mdc: capture the 16 data bits of a read, after the turnaround
            if (readOpReg && bitReg >= `MII_DATA_BIT) begin
              rdNext = {rdReg[14:0], mdioIn};
            end
          end else if (bitReg == `MII_LAST_BIT) begin
            stateNext = MG_IDLE;
            doneNext  = 1'b1;
            oeNext    = 1'b0;
          end else begin
            // falling mdc: present the next frame bit
            bitNext = bitReg + 6'h01;
            if (bitNext > `MII_PRE_BITS) begin
              shNext = {shReg[30:0], 1'b0};
            end
            outNext = (bitNext < `MII_PRE_BITS) ? 1'b1 :
                      (bitNext == `MII_PRE_BITS) ? shReg[31] : shReg[30];
            oeNext  = !(readOpReg && bitNext >= `MII_TA_BIT);
          end
        end
      end
    endcase
  end

  // state registers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      stateReg  <= MG_IDLE;
      divReg    <= '0;
      mdcReg    <= 1'b0;
      bitReg    <= '0;
      shReg     <= '0;
      rdReg     <= '0;
      readOpReg <= 1'b0;
      doneReg   <= 1'b0;
      outReg    <= 1'b0;
      oeReg     <= 1'b0;
    end else if (ce) begin
      stateReg  <= stateNext;
      divReg    <= divNext;
      mdcReg    <= mdcNext;
      bitReg    <= bitNext;
      shReg     <= shNext;
      rdReg     <= rdNext;
      readOpReg <= readOpNext;
      doneReg   <= doneNext;
      outReg    <= outNext;
      oeReg     <= oeNext;
    end
  end

  // outputs
  assign busy    = (stateReg == MG_RUN);
  assign done    = doneReg;
  assign rdData  = rdReg;
  assign mdc     = mdcReg;
  assign mdioOut = outReg;
  assign mdioOe  = oeReg;
endmodule
`default_nettype wire

// ---- rtl/mac_collision_retry_mgmt_cmd.sv ----
// Purpose: collision window / retry limit and management command registers with their logic
// Assumes: classic Wishbone slave; tx events are one-cycle pulses from the transmit path
// Notes:   8-bit accesses are acknowledged but change nothing and read zero
`timescale 1ns/1ps
`default_nettype none
`include "mac_cfg.svh"

module mac_collision_retry_mgmt_cmd #(
  parameter int ADDR_W   = 8,                 // byte address width
  parameter int CNT_W    = 8,                 // slot byte counter width
  parameter int HALF_DIV = 20                 // core cycles per mdc half period
) (
  input  wire logic              core_clk,    // 100 MHz system clock
  input  wire logic              rstn,        // async reset, active low
  input  wire logic              ce,          // clock enable, freezes state
  input  wire logic              wb_cyc_i,    // wishbone cycle
  input  wire logic              wb_stb_i,    // wishbone strobe
  input  wire logic              wb_we_i,     // wishbone write enable
  input  wire logic [ADDR_W-1:0] wb_adr_i,    // wishbone byte address
  input  wire logic [3:0]        wb_sel_i,    // wishbone byte selects
  input  wire logic [31:0]       wb_dat_i,    // wishbone write data
  output logic      [31:0]       wb_dat_o,    // wishbone read data
  output logic                   wb_ack_o,    // wishbone acknowledge
  input  wire logic              txStart,     // pulse: start of an attempt (first preamble byte)
  input  wire logic              txByte,      // pulse: one byte sent on the wire
  input  wire logic              txCollision, // pulse: collision seen
  input  wire logic              txEnd,       // pulse: frame sent without collision
  output logic                   inWindow,    // level: inside the collision window
  output logic [CNT_W-1:0]       slotCount,   // bytes sent in this attempt
  output logic                   retryReq,    // pulse: back off and retry
  output logic                   excessAbort, // pulse: abort, excessive collisions
  output logic                   lateColl,    // pulse: collision after the window
  output logic                   mdc,         // management clock
  output logic                   mdioOut,     // mdio drive value
  output logic                   mdioOe,      // mdio drive enable, high while driving
  input  wire logic              mdioIn       // mdio pin level
);
  import mac_pkg::*;

  // ==========================================
  // register bus decode
  logic        ackReg, ackNext;
  logic [31:0] datReg, datNext;
  logic        wbReq, selOk, inRange, wrEn, rdEn;
  logic [3:0]  idx;
  logic [31:0] byteMask;
  alias_op_t   aliasOp;

  // request qualification
  always_comb begin
    wbReq    = wb_cyc_i && wb_stb_i && !ackReg;
    idx      = wb_adr_i[5:2];
    inRange  = (wb_adr_i[ADDR_W-1:6] == '0);
    selOk    = (wb_sel_i == `SEL_LO) || (wb_sel_i == `SEL_HI) || (wb_sel_i == `SEL_ALL);
    wrEn     = wbReq && wb_we_i && selOk && inRange;
    rdEn     = wbReq && !wb_we_i && selOk && inRange;
    byteMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    aliasOp  = alias_op_t'(idx[1:0]);
  end

  // merge a write, plain or through a set / clear / invert alias
  function automatic logic [31:0] applyAlias(input logic [31:0] cur, input logic [31:0] wd,
                                             input logic [31:0] m, input alias_op_t op);
    logic [31:0] r;
    r = cur;
    unique case (op)
      OP_WRITE: r = (cur & ~m) | (wd & m);
      OP_SET:   r = cur | (wd & m);
      OP_CLR:   r = cur & ~(wd & m);
      OP_INV:   r = cur ^ (wd & m);
    endcase
    return r;
  endfunction

  // ==========================================
  // configuration registers
  logic [5:0]  cwReg, cwNext;
  logic [3:0]  rlReg, rlNext;
  logic        scanReg, scanNext;
  logic        readReg, readNext;
  logic [15:0] wdatReg, wdatNext;
  logic [4:0]  phyReg, phyNext;
  logic [4:0]  regaReg, regaNext;
  logic [15:0] rdatReg, rdatNext;
  logic        pendRdReg, pendRdNext;
  logic        pendWrReg, pendWrNext;
  logic [31:0] clrtImage, mcmdImage, madrImage, indImage, mergeVal;
  logic        startCyc, startRead, setRd, setWr;
  logic        engBusy, engDone;
  logic [15:0] engData;
  logic        startedRead, startedReadNext;

  // register images; unlisted bits stay zero
  always_comb begin
    clrtImage = '0;
    clrtImage[`CW_MSB:`CW_LSB] = cwReg;
    clrtImage[`RL_MSB:`RL_LSB] = rlReg;
    mcmdImage = '0;
    mcmdImage[`SCAN_BIT] = scanReg;
    mcmdImage[`READ_BIT] = readReg;
    madrImage = '0;
    madrImage[`PHY_MSB:`PHY_LSB]   = phyReg;
    madrImage[`REGA_MSB:`REGA_LSB] = regaReg;
    indImage = '0;
    indImage[`BUSY_BIT] = engBusy;
  end

  // register writes and command requests
  always_comb begin
    cwNext     = cwReg;
    rlNext     = rlReg;
    scanNext   = scanReg;
    readNext   = readReg;
    wdatNext   = wdatReg;
    phyNext    = phyReg;
    regaNext   = regaReg;
    rdatNext   = rdatReg;
    setRd      = 1'b0;
    setWr      = 1'b0;
    mergeVal   = '0;
    if (wrEn) begin
      if (idx <= `IDX_CLRT_INV) begin
        mergeVal = applyAlias(clrtImage, wb_dat_i, byteMask, aliasOp);
        cwNext   = mergeVal[`CW_MSB:`CW_LSB];
        rlNext   = mergeVal[`RL_MSB:`RL_LSB];
      end else if (idx <= `IDX_MCMD_INV) begin
        mergeVal = applyAlias(mcmdImage, wb_dat_i, byteMask, aliasOp);
        scanNext = mergeVal[`SCAN_BIT];
        readNext = mergeVal[`READ_BIT];
        setRd    = mergeVal[`READ_BIT] && !readReg;
      end else if (idx == `IDX_MWTD) begin
        mergeVal = applyAlias({16'h0000, wdatReg}, wb_dat_i, byteMask, OP_WRITE);
        wdatNext = mergeVal[`WDAT_MSB:0];
        setWr    = !readReg;
      end else if (idx == `IDX_MADR) begin
        mergeVal = applyAlias(madrImage, wb_dat_i, byteMask, OP_WRITE);
        phyNext  = mergeVal[`PHY_MSB:`PHY_LSB];
        regaNext = mergeVal[`REGA_MSB:`REGA_LSB];
      end
    end
    // every finished read refreshes the read data, scan reads included
    if (engDone && startedRead) begin
      rdatNext = engData;
    end
  end

  // ==========================================
  // management command scheduling

  // a request that arrives while the engine runs waits; set wins over clear
  always_comb begin
    startCyc        = !engBusy && (pendWrReg || pendRdReg || scanReg);
    startRead       = !pendWrReg;
    pendWrNext      = (pendWrReg && !(startCyc && !startRead)) || setWr;
    pendRdNext      = (pendRdReg && !(startCyc && startRead)) || setRd;
    startedReadNext = startCyc ? startRead : startedRead;
  end

  mgmt_cycle_engine #(
    .HALF_DIV (HALF_DIV)
  ) u_engine (
    .core_clk (core_clk),
    .rstn     (rstn),
    .ce       (ce),
    .start    (startCyc),
    .isRead   (startRead),
    .phyAddr  (phyReg),
    .regAddr  (regaReg),
    .wrData   (wdatReg),
    .busy     (engBusy),
    .done     (engDone),
    .rdData   (engData),
    .mdc      (mdc),
    .mdioOut  (mdioOut),
    .mdioOe   (mdioOe),
    .mdioIn   (mdioIn)
  );

  // ==========================================
  // bus answer
  always_comb begin
    ackNext = wbReq;
    datNext = datReg;
    if (wbReq) begin
      datNext = '0;
    end
    if (rdEn) begin
      unique case (idx)
        `IDX_CLRT, `IDX_CLRT_SET, `IDX_CLRT_CLR, `IDX_CLRT_INV: datNext = clrtImage;
        `IDX_MCMD, `IDX_MCMD_SET, `IDX_MCMD_CLR, `IDX_MCMD_INV: datNext = mcmdImage;
        `IDX_MRDD: datNext = {16'h0000, rdatReg};
        `IDX_MWTD: datNext = {16'h0000, wdatReg};
        `IDX_MADR: datNext = madrImage;
        `IDX_MIND: datNext = indImage;
        default:   datNext = '0;
      endcase
    end
  end

  // ==========================================
  // collision window and retry counting
  tx_state_t        txReg, txNext;
  logic [CNT_W-1:0] cntReg, cntNext;
  logic [3:0]       tryReg, tryNext;
  logic             retryReg, retryNext;
  logic             abortReg, abortNext;
  logic             lateReg, lateNext;

  // per attempt window tracking
  always_comb begin
    txNext    = txReg;
    cntNext   = cntReg;
    tryNext   = tryReg;
    retryNext = 1'b0;
    abortNext = 1'b0;
    lateNext  = 1'b0;
    unique case (txReg)
      TX_IDLE: begin
        if (txStart) begin
          txNext  = TX_WINDOW;
          cntNext = '0;
        end
      end
      TX_WINDOW: begin
        if (txCollision) begin
          txNext = TX_IDLE;
          if (tryReg >= rlReg) begin
            abortNext = 1'b1;
            tryNext   = '0;
          end else begin
            retryNext = 1'b1;
            tryNext   = tryReg + 4'h1;
          end
        end else if (txEnd) begin
          txNext  = TX_IDLE;
          tryNext = '0;
        end else if (txByte) begin
          cntNext = cntReg + CNT_W'(1);
          if (cntNext >= CNT_W'(cwReg)) begin
            txNext = TX_LATE;
          end
        end
      end
      TX_LATE: begin
        if (txByte) begin
          cntNext = (cntReg == '1) ? cntReg : cntReg + CNT_W'(1);
        end
        if (txCollision || txEnd) begin
          txNext   = TX_IDLE;
          tryNext  = '0;
          lateNext = txCollision;
        end
      end
    endcase
  end

  // ==========================================
  // state registers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ackReg      <= 1'b0;
      datReg      <= '0;
      cwReg       <= `CW_RST;
      rlReg       <= `RL_RST;
      scanReg     <= 1'b0;
      readReg     <= 1'b0;
      wdatReg     <= '0;
      phyReg      <= '0;
      regaReg     <= '0;
      rdatReg     <= '0;
      pendRdReg   <= 1'b0;
      pendWrReg   <= 1'b0;
      startedRead <= 1'b0;
      txReg       <= TX_IDLE;
      cntReg      <= '0;
      tryReg      <= '0;
      retryReg    <= 1'b0;
      abortReg    <= 1'b0;
      lateReg     <= 1'b0;
    end else if (ce) begin
      ackReg      <= ackNext;
      datReg      <= datNext;
      cwReg       <= cwNext;
      rlReg       <= rlNext;
      scanReg     <= scanNext;
      readReg     <= readNext;
      wdatReg     <= wdatNext;
      phyReg      <= phyNext;
      regaReg     <= regaNext;
      rdatReg     <= rdatNext;
      pendRdReg   <= pendRdNext;
      pendWrReg   <= pendWrNext;
      startedRead <= startedReadNext;
      txReg       <= txNext;
      cntReg      <= cntNext;
      tryReg      <= tryNext;
      retryReg    <= retryNext;
      abortReg    <= abortNext;
      lateReg     <= lateNext;
    end
  end

  // outputs
  assign wb_ack_o    = ackReg;
  assign wb_dat_o    = datReg;
  assign inWindow    = (txReg == TX_WINDOW);
  assign slotCount   = cntReg;
  assign retryReq    = retryReg;
  assign excessAbort = abortReg;
  assign lateColl    = lateReg;
endmodule
`default_nettype wire

// ---- bench/mac_collision_retry_mgmt_cmd_asserts.sv ----
// Purpose: port checks for bus answers, window counting and collisions
// Assumes: one clock domain, reset rstn
// Notes:   bound to every instance of the block
`timescale 1ns/1ps
`default_nettype none
module mac_crm_checker #(
  parameter int ADDR_W   = 8,  // address width
  parameter int CNT_W    = 8,  // counter width
  parameter int HALF_DIV = 20  // mdc half period
) (
  input wire logic              core_clk,    // clock
  input wire logic              rstn,        // reset
  input wire logic              ce,          // enable
  input wire logic              wb_cyc_i,    // cycle
  input wire logic              wb_stb_i,    // strobe
  input wire logic              wb_we_i,     // write
  input wire logic [ADDR_W-1:0] wb_adr_i,    // address
  input wire logic [3:0]        wb_sel_i,    // selects
  input wire logic [31:0]       wb_dat_o,    // read data
  input wire logic              wb_ack_o,    // ack
  input wire logic              txByte,      // byte
  input wire logic              txCollision, // collision
  input wire logic              txEnd,       // end
  input wire logic              inWindow,    // window
  input wire logic [CNT_W-1:0]  slotCount,   // count
  input wire logic              retryReq,    // retry
  input wire logic              excessAbort  // abort
);
  // ==========================================
  // assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  property p_ack; wb_cyc_i && wb_stb_i && ce && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  property p_one; wb_ack_o && ce |=> !wb_ack_o; endproperty
  a_one: assert property (p_one) else $error("ack too long");
  property p_clrt; wb_ack_o && !wb_we_i && wb_adr_i[7:4] == 4'h0 |->
    wb_dat_o[31:14] == 18'h0 && wb_dat_o[7:4] == 4'h0; endproperty
  a_clrt: assert property (p_clrt) else $error("window reg spare bits");
  property p_mcmd; wb_ack_o && !wb_we_i && wb_adr_i[7:4] == 4'h1 |->
    wb_dat_o[31:2] == 30'h0; endproperty
  a_mcmd: assert property (p_mcmd) else $error("command spare bits");
  property p_byte; wb_ack_o && !wb_we_i && !(wb_sel_i inside {4'h3, 4'hC, 4'hF}) |->
    wb_dat_o == 32'h0; endproperty
  a_byte: assert property (p_byte) else $error("byte read not zero");
  property p_win; $rose(inWindow) |-> slotCount == '0; endproperty
  a_win: assert property (p_win) else $error("window count not cleared");
  property p_cnt; inWindow && txByte && !txCollision && !txEnd && ce |=>
    slotCount == $past(slotCount) + 1'h1; endproperty
  a_cnt: assert property (p_cnt) else $error("byte not counted");
  property p_coll; inWindow && txCollision && ce |=> retryReq != excessAbort; endproperty
  a_coll: assert property (p_coll) else $error("collision answer");
endmodule
bind mac_collision_retry_mgmt_cmd mac_crm_checker #(.ADDR_W(ADDR_W), .CNT_W(CNT_W),
  .HALF_DIV(HALF_DIV)) mac_crm_checker_inst (.core_clk, .rstn, .ce, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .txByte, .txCollision, .txEnd,
  .inWindow, .slotCount, .retryReq, .excessAbort);
`default_nettype wire

// ---- bench/phy_mgmt_model.sv ----
// Purpose: phy side of the management line, answers reads, records writes
// Assumes: a frame of 64 bits starts when mdioOe rises; line has a pull-up
// Notes:   read data is a pattern of the phy and register address
`timescale 1ns/1ps
`default_nettype none
module phy_mgmt_model (
  input  wire logic   mdc,     // clock
  input  wire logic   mdioOut, // mac value
  input  wire logic   mdioOe,  // mac enable
  output logic        mdioIn,  // line level
  output logic [15:0] lastWr,  // last write data
  output logic [9:0]  lastAdr, // last phy and reg
  output int          nWr,     // writes seen
  output int          nRd      // reads seen
);
  logic [63:0] frm = 64'h0; // sampled bits
  logic [16:0] rv;          // turnaround and data
  logic        drv = 1'h0;  // phy drives
  logic        dv = 1'h0;   // phy value
  int          n = 64;      // rises in frame
  initial begin
    nWr = 0;
    nRd = 0;
    lastWr = 16'h0;
    lastAdr = 10'h0;
  end
  // line resolution, pulled up when released
  assign mdioIn = mdioOe ? mdioOut : (drv ? dv : 1'h1);
  assign rv = {1'h0, 16'hA500 ^ {6'h0, frm[27:18]}};
  always @(posedge mdioOe) n = 0;
  // sample on rising mdc, decode at frame end
  always @(posedge mdc) begin
    if (n < 64) begin
      frm[63 - n] = mdioIn;
      n++;
      if (n == 64) begin
        lastAdr = frm[27:18];
        if (frm[29:28] == 2'h1) begin
          nWr++;
          lastWr = frm[15:0];
        end
        if (frm[29:28] == 2'h2) nRd++;
      end
    end
  end
  // read bits change after mdc falls, msb first
  always @(negedge mdc) begin
    drv = n >= 47 && n < 64 && frm[29:28] == 2'h2;
    dv = rv[63 - n];
  end
endmodule
`default_nettype wire

// ---- bench/test_mac_collision_retry_mgmt_cmd.sv ----
// Purpose: self-checking bench for the collision and management block
// Assumes: phy model on mdio, ce high except one freeze check
// Notes:   HALF_DIV cut to 2 to shorten frames
`timescale 1ns/1ps
`default_nettype none
module test_mac_collision_retry_mgmt_cmd;
  // ==========================================
  // signals
  logic        core_clk = 1'h0;
  logic        rstn = 1'h0;
  logic        ce = 1'h1;
  logic        cyc = 1'h0;
  logic        stb = 1'h0;
  logic        we = 1'h0;
  logic [7:0]  adr = 8'h0;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [3:0]  txp = 4'h0; // start byte coll end
  logic [31:0] rdat;
  logic [7:0]  slotCount;
  logic [15:0] lastWr;
  logic [9:0]  lastAdr;
  logic        ack, inWindow, retryReq, excessAbort, lateColl, mdc, mdioOut, mdioOe, mdioIn;
  int          nWr, nRd;
  int          mismatches = 0, numChecks = 0, cycles = 0;
  always #5 core_clk = ~core_clk;
  mac_collision_retry_mgmt_cmd #(.HALF_DIV(2)) mac_collision_retry_mgmt_cmd_inst (
    .core_clk, .rstn, .ce, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .txStart(txp[3]), .txByte(txp[2]), .txCollision(txp[1]), .txEnd(txp[0]), .inWindow,
    .slotCount, .retryReq, .excessAbort, .lateColl, .mdc, .mdioOut, .mdioOe, .mdioIn);
  phy_mgmt_model phy_mgmt_model_inst (.mdc, .mdioOut, .mdioOe, .mdioIn, .lastWr, .lastAdr,
    .nWr, .nRd);
  // compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    numChecks++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got %h want %h", $time, g, e);
    end
  endtask
  // one classic bus cycle, entered just after a rising edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d, output logic [31:0] q);
    int t;
    t = 0;
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    do begin
      @(posedge core_clk);
      t++;
    end while (ack !== 1'h1 && t < 50);
    chk({31'h0, ack}, 32'h1);
    q = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    logic [31:0] q;
    wb(1'h1, a, s, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [3:0] s, input logic [31:0] e);
    logic [31:0] q;
    wb(1'h0, a, s, 32'h0, q);
    chk(q, e);
  endtask
  // one transmit event, then look at window and pulses under a mask
  task automatic tx(input logic [3:0] p, input logic [3:0] m, input logic [3:0] e);
    txp <= p;
    @(posedge core_clk);
    txp <= 4'h0;
    @(negedge core_clk);
    chk({28'h0, {inWindow, retryReq, excessAbort, lateColl} & m}, {28'h0, e});
    @(posedge core_clk);
  endtask
  task automatic waitc(input logic r, input int goal);
    int t;
    t = 0;
    while ((r ? nRd : nWr) < goal && t < 2000) begin
      @(posedge core_clk);
      t++;
    end
    chk({31'h0, t < 2000}, 32'h1);
  endtask
  // ==========================================
  // scenarios
  task automatic t_regs;
    logic [75:0] tbl [7];
    tbl = '{{8'h00, 4'hF, 32'hFFFFFFFF, 32'h00003F0F}, {8'h00, 4'h1, 32'h0, 32'h00003F0F},
            {8'h00, 4'h3, 32'h00002A05, 32'h00002A05}, {8'h08, 4'hF, 32'h4, 32'h00002A01},
            {8'h04, 4'h3, 32'h100, 32'h00002B01}, {8'h0C, 4'hF, 32'h10F, 32'h00002A0E},
            {8'h10, 4'h1, 32'h1, 32'h0}};
    rd(8'h00, 4'hF, 32'h0000370F);
    rd(8'h10, 4'hF, 32'h0);
    for (int i = 0; i < 7; i++) begin
      wr(tbl[i][75:68], tbl[i][67:64], tbl[i][63:32]);
      rd(tbl[i][75:68], 4'hF, tbl[i][31:0]);
    end
    rd(8'h00, 4'h1, 32'h0);
    rd(8'hC0, 4'hF, 32'h0);
    wr(8'h00, 4'hF, 32'h00000402);
  endtask
  task automatic t_win;
    tx(4'h8, 4'h8, 4'h8);
    repeat (3) tx(4'h4, 4'h8, 4'h8);
    @(negedge core_clk);
    chk({24'h0, slotCount}, 32'h3);
    @(posedge core_clk);
    tx(4'h4, 4'h8, 4'h0);
    tx(4'h2, 4'hF, 4'h1);
    tx(4'h1, 4'h8, 4'h0);
    for (int k = 0; k < 4; k++) begin
      tx(4'h8, 4'h8, 4'h8);
      tx(4'h2, 4'h7, (k == 2) ? 4'h2 : 4'h4);
    end
    // clock enable low: a start must not open the window
    ce <= 1'h0;
    tx(4'h8, 4'h8, 4'h0);
    ce <= 1'h1;
  endtask
  task automatic t_mgmt;
    int n;
    wr(8'h28, 4'hF, 32'h00000311);
    n = nWr;
    wr(8'h24, 4'h3, 32'h0000BEEF);
    waitc(1'h0, n + 1);
    chk({16'h0, lastWr}, 32'h0000BEEF);
    chk({22'h0, lastAdr}, 32'h71);
    n = nRd;
    wr(8'h14, 4'hF, 32'h1);
    waitc(1'h1, n + 1);
    repeat (8) @(posedge core_clk);
    rd(8'h20, 4'hF, 32'h0000A571);
    repeat (300) @(posedge core_clk);
    chk(nRd, n + 1);
    wr(8'h18, 4'hF, 32'h1);
    wr(8'h1C, 4'h3, 32'h2);
    rd(8'h10, 4'hF, 32'h2);
    waitc(1'h1, nRd + 3);
    wr(8'h28, 4'hF, 32'h00000705);
    waitc(1'h1, nRd + 2);
    repeat (8) @(posedge core_clk);
    rd(8'h20, 4'hF, 32'h0000A5E5);
    wr(8'h1C, 4'h3, 32'h2);
    repeat (300) @(posedge core_clk);
    n = nRd;
    repeat (300) @(posedge core_clk);
    chk(nRd, n);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", numChecks, mismatches);
    if (mismatches == 0 && numChecks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge core_clk);
    rstn <= 1'h1;
    @(posedge core_clk);
    t_regs;
    t_win;
    t_mgmt;
    tally_and_finish;
  end
  // hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      tally_and_finish;
    end
  end
endmodule
`default_nettype wire
